/* hw/irq_port_pkg.sv */
// Purpose: constants shared by the bus port and interrupt front end
// Assumes: 8-bit data, 5-bit register select, 16 fixed-priority channels
// Notes: register indexes equal the register select value
//
// Contract
// - read with select and strobe: drive addressed register, then acknowledge
// - read ends on select or strobe release: ack high, then float ack and data
// - write with select and strobe: decode select, load register, then acknowledge
// - write ends on select or strobe release: ack high, then float it
// - interrupt request low while any of 16 channels has an unmasked pending request
// - vector acknowledge plus strobe: place 8-bit vector on data, then acknowledge
// - vector cycle ends on strobe or acknowledge release: ack high, float all
// - request drops after vector cycle unless other interrupts stay pending
// - grant in low and pending: send vector; otherwise pass grant down
// - while passing the grant, drive neither data nor ack
// - grant out says neither this nor any higher device requests
// - reset clears all registers but timer data, serial data, tx status, vector
// - reset stops timers and disables serial receiver and transmitter
// - reset disables every channel and clears every pending interrupt
// - reset makes general lines inputs, timer outputs low, outputs negated
// - reset loads vector register with 0f hex
// - vector belongs to highest-priority unmasked pending channel of 16
// - channel codes 15 down to 0 in fixed priority order
// - masked pending interrupts are never presented
// - vector bits 7..4 from vector register, bits 3..0 the channel code
// - delivering a channel's vector clears its pending bit
package irq_port_pkg;
  localparam int DATA_W = 8;
  localparam int SEL_W = 5;
  localparam int CHAN_N = 16;
  localparam int CODE_W = 4;
  localparam int REG_N = 32;

  // register indexes
  localparam logic [SEL_W-1:0] REG_GPIO_DATA = 5'h00;
  localparam logic [SEL_W-1:0] REG_ACTIVE_EDGE = 5'h01;
  localparam logic [SEL_W-1:0] REG_DIRECTION = 5'h02;
  localparam logic [SEL_W-1:0] REG_ENABLE_HI = 5'h03;
  localparam logic [SEL_W-1:0] REG_ENABLE_LO = 5'h04;
  localparam logic [SEL_W-1:0] REG_PENDING_HI = 5'h05;
  localparam logic [SEL_W-1:0] REG_PENDING_LO = 5'h06;
  localparam logic [SEL_W-1:0] REG_SERVICE_HI = 5'h07;
  localparam logic [SEL_W-1:0] REG_SERVICE_LO = 5'h08;
  localparam logic [SEL_W-1:0] REG_MASK_HI = 5'h09;
  localparam logic [SEL_W-1:0] REG_MASK_LO = 5'h0a;
  localparam logic [SEL_W-1:0] REG_VECTOR = 5'h0b;
  localparam logic [SEL_W-1:0] REG_TIMER_A_CTRL = 5'h0c;
  localparam logic [SEL_W-1:0] REG_TIMER_B_CTRL = 5'h0d;
  localparam logic [SEL_W-1:0] REG_TIMER_CD_CTRL = 5'h0e;
  localparam logic [SEL_W-1:0] REG_SERIAL_RX_STATUS = 5'h15;
  localparam logic [SEL_W-1:0] REG_TX_STATUS = 5'h16;

  // entries of the plain store cleared by reset; timer data, serial data and tx status keep their value
  localparam logic [REG_N-1:0] STORE_CLEAR_MASK = 32'h0038_7fff;

  // vector register fields, serial enable bit and timer mode width
  localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h0f;
  localparam int VEC_BASE_LSB = 4;
  localparam int VEC_SOFT_EOI_BIT = 3;
  localparam int SERIAL_ENABLE_BIT = 0;
  localparam int TIMER_MODE_W = 4;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ACCESS = 3'b001,
    BUS_FETCH = 3'b010,
    BUS_ACK = 3'b011,
    BUS_RELEASE = 3'b100,
    BUS_PASS = 3'b101
  } bus_state_e;
endpackage

/* hw/reg_store.sv */
// Purpose: plain register storage behind the bus port
// Assumes: one write port, one read port, read data registered
// Notes: entries flagged in CLEAR_MASK are zeroed by reset, others keep value
`timescale 1ns/1ns
module reg_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int ADDR_W = 5,
  parameter logic [DEPTH-1:0] CLEAR_MASK = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData,
  // whole contents, for control bits that steer other logic
  output logic [DEPTH*WIDTH-1:0] contents
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [WIDTH-1:0] rdData_nxt;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
        if (reset && CLEAR_MASK[i]) begin
          mem_nxt[i] = '0;
        end else if (wrEn && wrAddr == ADDR_W'(i)) begin
          mem_nxt[i] = wrData;
        end else begin
          mem_nxt[i] = mem_r[i];
        end
      end
      always_ff @(posedge clk) begin
        mem_r[i] <= mem_nxt[i];
      end
      assign contents[i*WIDTH +: WIDTH] = mem_r[i];
    end
  endgenerate

  always_comb begin
    rdData_nxt = reset ? '0 : mem_r[rdAddr];
  end

  always_ff @(posedge clk) begin
    rdData <= rdData_nxt;
  end
endmodule

/* hw/async_bus_port_vectored_irq.sv */
// Purpose: asynchronous strobe bus port with vectored, chained interrupt front end
// Assumes: select, direction and data are stable while the strobes are asserted
// Notes: channel inputs are single-cycle events on clk, indexed by channel code
`timescale 1ns/1ns
module async_bus_port_vectored_irq
  import irq_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor bus
  input wire logic chipSelectN,
  input wire logic dataStrobeN,
  input wire logic readNotWrite,
  input wire logic [SEL_W-1:0] registerSelect,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic transferAckNOut,
  output logic transferAckNOe,
  // interrupt request and acknowledge chain
  output logic irqN,
  input wire logic vectorAckStrobeN,
  input wire logic chainGrantInN,
  output logic chainGrantOutN,
  // interrupt sources
  input wire logic [CHAN_N-1:0] channelEvent,
  // general lines
  input wire logic [DATA_W-1:0] generalLinesIn,
  output logic [DATA_W-1:0] generalLinesOe,
  // timer and serial control levels
  output logic [3:0] timerRun,
  output logic [3:0] timerOut,
  output logic serialRxEnable,
  output logic serialTxEnable
);
  localparam int SYNC_N = 4 + DATA_W;
  localparam int S_CS = 0;
  localparam int S_DS = 1;
  localparam int S_VACK = 2;
  localparam int S_GRANT = 3;
  localparam int S_LINES = 4;

  // input synchronisers: three stages, change accepted when stages two and three agree
  logic [SYNC_N-1:0] syncRaw;
  logic [SYNC_N-1:0] sync1_r, sync2_r, sync3_r, syncLvl_r;
  logic [SYNC_N-1:0] sync1_nxt, sync2_nxt, sync3_nxt, syncLvl_nxt;

  // general lines are pins too, so they share the filter and a glitch caught by one sample only never reaches a read
  assign syncRaw = {generalLinesIn, chainGrantInN, vectorAckStrobeN, dataStrobeN, chipSelectN};

  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_comb begin
        if (reset) begin
          sync1_nxt[g] = 1'b1;
          sync2_nxt[g] = 1'b1;
          sync3_nxt[g] = 1'b1;
          syncLvl_nxt[g] = 1'b1;
        end else begin
          sync1_nxt[g] = syncRaw[g];
          sync2_nxt[g] = sync1_r[g];
          sync3_nxt[g] = sync2_r[g];
          syncLvl_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : syncLvl_r[g];
        end
      end
      always_ff @(posedge clk) begin
        sync1_r[g] <= sync1_nxt[g];
        sync2_r[g] <= sync2_nxt[g];
        sync3_r[g] <= sync3_nxt[g];
        syncLvl_r[g] <= syncLvl_nxt[g];
      end
    end
  endgenerate

  logic selected, strobed, vackOn, grantIn;
  assign selected = ~syncLvl_r[S_CS];
  assign strobed = ~syncLvl_r[S_DS];
  assign vackOn = ~syncLvl_r[S_VACK];
  assign grantIn = ~syncLvl_r[S_GRANT];
  logic [DATA_W-1:0] linesSync;
  assign linesSync = syncLvl_r[S_LINES +: DATA_W];

  // interrupt state
  logic [CHAN_N-1:0] enable_r, pending_r, service_r, mask_r;
  logic [CHAN_N-1:0] enable_nxt, pending_nxt, service_nxt, mask_nxt;
  logic [DATA_W-1:0] vector_r, vector_nxt;
  logic [CHAN_N-1:0] presented;
  logic anyRequest;
  logic [CODE_W-1:0] topCode;

  assign presented = pending_r & mask_r;
  assign anyRequest = |presented;

  // fixed priority: the channel code is the bit index, 15 highest
  always_comb begin
    topCode = '0;
    for (int c = 0; c < CHAN_N; c++) begin
      if (presented[c]) begin
        topCode = CODE_W'(c);
      end
    end
  end

  // bus cycle state
  bus_state_e state_r, state_nxt;
  logic isRead_r, isRead_nxt;
  logic isVector_r, isVector_nxt;
  logic [SEL_W-1:0] sel_r, sel_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] dataOut_nxt;
  logic dataOe_nxt, ackOut_nxt, ackOe_nxt, grantOut_nxt;
  logic storeWr;
  logic [DATA_W-1:0] storeRd;
  logic [REG_N*DATA_W-1:0] storeAll;
  logic [DATA_W-1:0] readMux;
  logic deliver;
  logic [CHAN_N-1:0] deliverMask;
  logic accessEnd, vackEnd;

  assign accessEnd = ~selected | ~strobed;
  assign vackEnd = ~strobed | ~vackOn;
  assign storeWr = (state_r == BUS_ACCESS) && !isRead_r && !isVector_r;
  assign deliver = (state_r == BUS_IDLE) && vackOn && strobed && grantIn && anyRequest;
  assign deliverMask = deliver ? (CHAN_N'(1) << topCode) : '0;

  reg_store #(
    .WIDTH(DATA_W),
    .DEPTH(REG_N),
    .ADDR_W(SEL_W),
    .CLEAR_MASK(STORE_CLEAR_MASK)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .wrEn(storeWr),
    .wrAddr(sel_r),
    .wrData(wdata_r),
    .rdAddr(sel_r),
    .rdData(storeRd),
    .contents(storeAll)
  );

  // read data selection for the addressed register
  always_comb begin
    case (sel_r)
      REG_GPIO_DATA: readMux = linesSync;
      REG_ENABLE_HI: readMux = enable_r[CHAN_N-1 -: DATA_W];
      REG_ENABLE_LO: readMux = enable_r[DATA_W-1:0];
      REG_PENDING_HI: readMux = pending_r[CHAN_N-1 -: DATA_W];
      REG_PENDING_LO: readMux = pending_r[DATA_W-1:0];
      REG_SERVICE_HI: readMux = service_r[CHAN_N-1 -: DATA_W];
      REG_SERVICE_LO: readMux = service_r[DATA_W-1:0];
      REG_MASK_HI: readMux = mask_r[CHAN_N-1 -: DATA_W];
      REG_MASK_LO: readMux = mask_r[DATA_W-1:0];
      // unused vector bits read as zero
      REG_VECTOR: readMux = {vector_r[DATA_W-1:VEC_BASE_LSB], vector_r[VEC_SOFT_EOI_BIT], 3'h0};
      default: readMux = storeRd;
    endcase
  end

  // bus sequencer
  always_comb begin
    state_nxt = state_r;
    isRead_nxt = isRead_r;
    isVector_nxt = isVector_r;
    sel_nxt = sel_r;
    wdata_nxt = wdata_r;
    dataOut_nxt = dataOut;
    dataOe_nxt = 1'b0;
    ackOut_nxt = 1'b1;
    ackOe_nxt = 1'b0;
    grantOut_nxt = 1'b0;
    if (reset) begin
      state_nxt = BUS_IDLE;
      isRead_nxt = 1'b0;
      isVector_nxt = 1'b0;
      sel_nxt = '0;
      wdata_nxt = '0;
      dataOut_nxt = '0;
    end else begin
      case (state_r)
        BUS_IDLE: begin
          if (vackOn && strobed) begin
            if (deliver) begin
              dataOut_nxt = {vector_r[DATA_W-1:VEC_BASE_LSB], topCode};
              dataOe_nxt = 1'b1;
              isVector_nxt = 1'b1;
              state_nxt = BUS_FETCH;
            end else if (grantIn) begin
              // no request here but grant in: this one stays silent and passes the grant down
              grantOut_nxt = 1'b1;
              state_nxt = BUS_PASS;
            end
          end else if (selected && strobed) begin
            isRead_nxt = readNotWrite;
            isVector_nxt = 1'b0;
            sel_nxt = registerSelect;
            wdata_nxt = dataIn;
            state_nxt = BUS_ACCESS;
          end
        end
        BUS_ACCESS: begin
          // store read data lands one cycle after the select is latched
          dataOe_nxt = isRead_r;
          state_nxt = BUS_FETCH;
        end
        BUS_FETCH: begin
          // read data goes out with the acknowledge; bus drive and vector data one cycle ahead
          if (!isVector_r && isRead_r) begin
            dataOut_nxt = readMux;
          end
          dataOe_nxt = isRead_r | isVector_r;
          ackOut_nxt = 1'b0;
          ackOe_nxt = 1'b1;
          state_nxt = BUS_ACK;
        end
        BUS_ACK: begin
          if (isVector_r ? vackEnd : accessEnd) begin
            ackOut_nxt = 1'b1;
            ackOe_nxt = 1'b1;
            state_nxt = BUS_RELEASE;
          end else begin
            dataOe_nxt = isRead_r | isVector_r;
            ackOut_nxt = 1'b0;
            ackOe_nxt = 1'b1;
          end
        end
        BUS_RELEASE: begin
          isVector_nxt = 1'b0;
          state_nxt = BUS_IDLE;
        end
        BUS_PASS: begin
          // grant passed down: this device keeps off data and ack
          if (vackEnd) begin
            state_nxt = BUS_IDLE;
          end else begin
            grantOut_nxt = 1'b1;
          end
        end
        default: state_nxt = BUS_IDLE;
      endcase
    end
  end

  // interrupt registers: hardware set wins over a software clear in the same cycle
  always_comb begin
    enable_nxt = enable_r;
    mask_nxt = mask_r;
    vector_nxt = vector_r;
    pending_nxt = pending_r & ~deliverMask;
    service_nxt = service_r;
    if (reset) begin
      enable_nxt = '0;
      pending_nxt = '0;
      service_nxt = '0;
      mask_nxt = '0;
      vector_nxt = VECTOR_RESET;
    end else begin
      if (vector_r[VEC_SOFT_EOI_BIT]) begin
        service_nxt = service_r | deliverMask;
      end
      if (!isRead_r && !isVector_r && state_r == BUS_ACCESS) begin
        case (sel_r)
          REG_ENABLE_HI: enable_nxt[CHAN_N-1 -: DATA_W] = wdata_r;
          REG_ENABLE_LO: enable_nxt[DATA_W-1:0] = wdata_r;
          REG_PENDING_HI: pending_nxt[CHAN_N-1 -: DATA_W] = pending_nxt[CHAN_N-1 -: DATA_W] & wdata_r;
          REG_PENDING_LO: pending_nxt[DATA_W-1:0] = pending_nxt[DATA_W-1:0] & wdata_r;
          REG_SERVICE_HI: service_nxt[CHAN_N-1 -: DATA_W] = service_nxt[CHAN_N-1 -: DATA_W] & wdata_r;
          REG_SERVICE_LO: service_nxt[DATA_W-1:0] = service_nxt[DATA_W-1:0] & wdata_r;
          REG_MASK_HI: mask_nxt[CHAN_N-1 -: DATA_W] = wdata_r;
          REG_MASK_LO: mask_nxt[DATA_W-1:0] = wdata_r;
          REG_VECTOR: vector_nxt = {wdata_r[DATA_W-1:VEC_SOFT_EOI_BIT], 3'h0};
          default: vector_nxt = vector_r;
        endcase
      end
      // disabling a channel drops its pending bit
      pending_nxt = pending_nxt & enable_nxt;
      pending_nxt = pending_nxt | (channelEvent & enable_r);
      // automatic end of interrupt keeps in-service low
      if (!vector_nxt[VEC_SOFT_EOI_BIT]) begin
        service_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    state_r <= state_nxt;
    isRead_r <= isRead_nxt;
    isVector_r <= isVector_nxt;
    sel_r <= sel_nxt;
    wdata_r <= wdata_nxt;
    dataOut <= dataOut_nxt;
    dataOe <= dataOe_nxt;
    transferAckNOut <= ackOut_nxt;
    transferAckNOe <= ackOe_nxt;
    chainGrantOutN <= ~grantOut_nxt;
    enable_r <= enable_nxt;
    pending_r <= pending_nxt;
    service_r <= service_nxt;
    mask_r <= mask_nxt;
    vector_r <= vector_nxt;
  end

  // request line follows presented state, so it drops once the last one is delivered
  logic irqN_nxt;

  always_comb begin
    if (reset) begin
      irqN_nxt = 1'b1;
    end else begin
      irqN_nxt = ~|(pending_nxt & mask_nxt);
    end
  end

  always_ff @(posedge clk) begin
    irqN <= irqN_nxt;
  end

  // tx status survives reset, so the transmitter waits for a fresh write before it runs
  logic txArmed_r, txArmed_nxt;

  always_comb begin
    txArmed_nxt = txArmed_r;
    if (reset) begin
      txArmed_nxt = 1'b0;
    end else if (storeWr && sel_r == REG_TX_STATUS) begin
      txArmed_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    txArmed_r <= txArmed_nxt;
  end

  // control levels taken from the plain store, cleared by reset except tx status, which txArmed_r gates
  always_comb begin
    generalLinesOe = storeAll[REG_DIRECTION*DATA_W +: DATA_W];
    timerRun[0] = |storeAll[REG_TIMER_A_CTRL*DATA_W +: TIMER_MODE_W];
    timerRun[1] = |storeAll[REG_TIMER_B_CTRL*DATA_W +: TIMER_MODE_W];
    timerRun[2] = |storeAll[REG_TIMER_CD_CTRL*DATA_W + TIMER_MODE_W +: TIMER_MODE_W];
    timerRun[3] = |storeAll[REG_TIMER_CD_CTRL*DATA_W +: TIMER_MODE_W];
    // counters live elsewhere; this block only guarantees the low level out of reset
    timerOut = 4'h0;
    serialRxEnable = storeAll[REG_SERIAL_RX_STATUS*DATA_W + SERIAL_ENABLE_BIT];
    serialTxEnable = txArmed_r && storeAll[REG_TX_STATUS*DATA_W + SERIAL_ENABLE_BIT];
  end
endmodule

/* sim/irq_port_props.sv */
// Purpose: port-level timing checks of the bus port and interrupt chain
// Assumes: the master holds chain grant steady around vector cycles
// Notes: three-edge input synchronisers set the lower ack bounds
`timescale 1ns/1ns
module irq_port_props
  import irq_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus inputs
  input wire logic chipSelectN,
  input wire logic dataStrobeN,
  input wire logic readNotWrite,
  input wire logic vectorAckStrobeN,
  input wire logic chainGrantInN,
  // device outputs
  input wire logic dataOe,
  input wire logic transferAckNOut,
  input wire logic transferAckNOe,
  input wire logic irqN,
  input wire logic chainGrantOutN,
  input wire logic [DATA_W-1:0] generalLinesOe,
  input wire logic [3:0] timerRun,
  input wire logic [3:0] timerOut,
  input wire logic serialRxEnable,
  input wire logic serialTxEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_ack_driven: assert property (!transferAckNOut |-> transferAckNOe)
    else $error("ack low while the pin is floating");
  chk_data_first: assert property ($fell(transferAckNOut) && (readNotWrite || !vectorAckStrobeN) |-> $past(dataOe))
    else $error("ack came before data was driven");
  chk_write_quiet: assert property (!transferAckNOut && !readNotWrite && vectorAckStrobeN |-> !dataOe)
    else $error("data bus driven during a write");
  chk_ack_held: assert property (!transferAckNOut && !dataStrobeN |=> !transferAckNOut)
    else $error("ack dropped while strobe still low");
  chk_ack_float: assert property ($rose(transferAckNOut) |-> transferAckNOe ##1 (!transferAckNOe && !dataOe))
    else $error("ack not driven high then floated");
  chk_ack_ends: assert property ($rose(dataStrobeN) && !transferAckNOut |-> ##[1:8] transferAckNOut)
    else $error("ack not ended after strobe release");
  chk_sync_lag: assert property ($fell(dataStrobeN) |-> transferAckNOut [*3])
    else $error("ack faster than the synchronisers allow");
  chk_reset_state: assert property ($fell(reset) |-> irqN && chainGrantOutN && !dataOe && !transferAckNOe
      && timerOut == 4'h0 && timerRun == 4'h0 && !serialRxEnable && !serialTxEnable && generalLinesOe == 8'h00)
    else $error("outputs not at rest after reset");
  chk_pass_quiet: assert property (!chainGrantOutN |-> !dataOe && !transferAckNOe)
    else $error("bus driven while passing the grant");
  chk_grant_chain: assert property (!chainGrantOutN |-> !chainGrantInN)
    else $error("grant passed without grant in");
endmodule

bind async_bus_port_vectored_irq irq_port_props chk (.clk, .reset, .chipSelectN, .dataStrobeN, .readNotWrite,
  .vectorAckStrobeN, .chainGrantInN, .dataOe, .transferAckNOut, .transferAckNOe, .irqN, .chainGrantOutN,
  .generalLinesOe, .timerRun, .timerOut, .serialRxEnable, .serialTxEnable);

/* sim/cpu_bus_model.sv */
// Purpose: processor side of the strobe bus, register and vector cycles
// Assumes: the ack line is pulled up while the device floats it
// Notes: an unanswered cycle gives up after a bounded wait, like a bus error
`timescale 1ns/1ns
module cpu_bus_model
  import irq_port_pkg::*;
(
  // clock
  input wire logic clk,
  // strobes and qualifiers
  output logic chipSelectN,
  output logic dataStrobeN,
  output logic readNotWrite,
  output logic vectorAckStrobeN,
  output logic [SEL_W-1:0] registerSelect,
  output logic [DATA_W-1:0] masterData,
  // answer seen on the bus
  input wire logic [DATA_W-1:0] busData,
  input wire logic ackWire,
  input wire logic busBusy
);
  initial begin
    chipSelectN = 1'b1;
    dataStrobeN = 1'b1;
    readNotWrite = 1'b1;
    vectorAckStrobeN = 1'b1;
    registerSelect = '0;
    masterData = 8'h5a;
  end

  task automatic cycle(input logic vec, input logic rnw, input logic [SEL_W-1:0] sel,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clk);
    #2;
    // all qualifiers settle together and hold until ack or until the 16-cycle wait runs out
    readNotWrite = rnw;
    registerSelect = sel;
    masterData = rnw ? masterData : wd;
    chipSelectN = vec;
    vectorAckStrobeN = !vec;
    dataStrobeN = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk);
      ok = (ackWire === 1'b0);
    end
    rd = busData;
    #2;
    chipSelectN = 1'b1;
    dataStrobeN = 1'b1;
    vectorAckStrobeN = 1'b1;
    // released data line shows the inverse so a stale value cannot match
    masterData = ~masterData;
    for (int i = 0; i < 16 && busBusy !== 1'b0; i++) @(posedge clk);
    // a bus that never lets go counts as a failed cycle
    if (busBusy !== 1'b0) ok = 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* sim/tb_top.sv */
// Purpose: self-checking bench for the bus port and vectored interrupt front end
// Assumes: random values from a fixed xorshift seed
// Notes: vector register bit 3 kept clear after the first vector write, so nesting never blocks channels
`timescale 1ns/1ns
module tb_top;
  import irq_port_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic chipSelectN, dataStrobeN, readNotWrite, vectorAckStrobeN;
  logic [SEL_W-1:0] registerSelect;
  logic [DATA_W-1:0] masterData, dataOut, busData, rd, base, linesOe;
  logic dataOe, transferAckNOut, transferAckNOe, irqN, chainGrantOutN, ok, rxEn, txEn;
  int grantCount = 0;
  int g0 = 0;
  logic chainGrantInN = 1'b0;
  logic [CHAN_N-1:0] channelEvent = '0;
  logic [CHAN_N-1:0] pend, mask;
  logic [DATA_W-1:0] lines = 8'h3c;
  logic [3:0] timerRun, timerOut;
  logic [31:0] seed = 32'hba92;
  logic [31:0] r;
  logic [SEL_W-1:0] sels [5] = '{REG_ACTIVE_EDGE, REG_MASK_HI, REG_MASK_LO, 5'h13, REG_DIRECTION};
  int nMismatch = 0;
  int checkCount = 0;
  wire ackWire = transferAckNOe ? transferAckNOut : 1'b1;
  assign busData = dataOe ? dataOut : masterData;

  async_bus_port_vectored_irq DUT (.clk, .reset, .chipSelectN, .dataStrobeN, .readNotWrite, .registerSelect,
    .dataIn(busData), .dataOut, .dataOe, .transferAckNOut, .transferAckNOe, .irqN, .vectorAckStrobeN,
    .chainGrantInN, .chainGrantOutN, .channelEvent, .generalLinesIn(lines), .generalLinesOe(linesOe),
    .timerRun, .timerOut, .serialRxEnable(rxEn), .serialTxEnable(txEn));
  cpu_bus_model cpu (.clk, .chipSelectN, .dataStrobeN, .readNotWrite, .vectorAckStrobeN, .registerSelect,
    .masterData, .busData, .ackWire, .busBusy(transferAckNOe | dataOe));

  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (chainGrantOutN === 1'b0) grantCount <= grantCount + 1;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [DATA_W-1:0] expVec(input logic [DATA_W-1:0] b, input logic [CHAN_N-1:0] p);
    logic [CODE_W-1:0] c;
    c = '0;
    for (int i = 0; i < CHAN_N; i++) if (p[i]) c = i[CODE_W-1:0];
    return {b[7:4], c};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [SEL_W-1:0] a, input logic [DATA_W-1:0] d);
    cpu.cycle(1'b0, 1'b0, a, d, rd, ok);
    check("write ack", ok, 1'b1);
  endtask
  task automatic rdchk(input string n, input logic [SEL_W-1:0] a, input logic [DATA_W-1:0] e);
    cpu.cycle(1'b0, 1'b1, a, 8'h00, rd, ok);
    check(n, {ok, rd}, {1'b1, e});
  endtask
  task automatic fire(input logic [CHAN_N-1:0] e);
    @(posedge clk);
    #2;
    channelEvent = e;
    @(posedge clk);
    #2;
    channelEvent = '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic drain(input logic [CHAN_N-1:0] m);
    logic [DATA_W-1:0] e;
    for (int n = 0; n < 16 && (pend & m) != 0; n++) begin
      e = expVec(base, pend & m);
      cpu.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
      check("vector", {ok, rd}, {1'b1, e});
      pend[e[3:0]] = 1'b0;
      if (m == 16'hffff) check("irq after vector", irqN, pend == 0);
    end
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #2;
    reset = 1'b0;
    for (int a = 1; a <= 21; a++) begin
      if (a < 15 || a > 18) rdchk("reset value", a[4:0], (a == 11) ? (VECTOR_RESET & 8'hf8) : 8'h00);
    end
    r = xs();
    #2;
    lines = r[7:0];
    rdchk("general lines", REG_GPIO_DATA, lines);
    for (int k = 0; k < 5; k++) begin
      r = xs();
      wr(sels[k], r[7:0]);
      rdchk("readback", sels[k], r[7:0]);
    end
    check("direction", linesOe, r[7:0]);
    wr(REG_ENABLE_HI, 8'hff);
    wr(REG_ENABLE_LO, 8'hff);
    wr(REG_MASK_HI, 8'hff);
    wr(REG_MASK_LO, 8'hff);
    base = VECTOR_RESET;
    pend = 16'h0400;
    fire(pend);
    drain(16'hffff);
    r = xs();
    wr(REG_VECTOR, {r[7:4], 1'b0, r[2:0]});
    rdchk("vector reg", REG_VECTOR, {r[7:4], 4'h0});
    base = {r[7:4], 4'h0};
    for (int p = 0; p < 4; p++) begin
      r = xs();
      pend = (p == 0) ? 16'hffff : (r[15:0] | 16'h0001);
      fire(pend);
      check("irq raised", irqN, 1'b0);
      drain(16'hffff);
    end
    r = xs();
    mask = r[31:16] | 16'h0001;
    pend = r[15:0] | 16'h0001;
    wr(REG_MASK_HI, mask[15:8]);
    wr(REG_MASK_LO, mask[7:0]);
    fire(pend);
    drain(mask);
    rdchk("pending hi", REG_PENDING_HI, pend[15:8]);
    rdchk("pending lo", REG_PENDING_LO, pend[7:0]);
    wr(REG_PENDING_HI, 8'h00);
    wr(REG_PENDING_LO, 8'h00);
    g0 = grantCount;
    cpu.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
    check("grant passed", {ok, grantCount != g0}, 2'b01);
    repeat (8) @(posedge clk);
    #2;
    chainGrantInN = 1'b1;
    wr(REG_MASK_LO, 8'hff);
    fire(16'h0008);
    g0 = grantCount;
    cpu.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
    check("grant blocked", {ok, grantCount != g0}, 2'b00);
    repeat (8) @(posedge clk);
    #2;
    chainGrantInN = 1'b0;
    repeat (4) @(posedge clk);
    cpu.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
    check("granted vector", {ok, rd}, {1'b1, base[7:4], 4'h3});
    // second reset in mid-run: kept registers survive, run levels drop
    r = xs();
    wr(5'h10, r[7:0]);
    wr(REG_TIMER_A_CTRL, 8'h01);
    wr(REG_TX_STATUS, 8'h01);
    check("run levels", {timerRun[0], txEn}, 2'b11);
    @(posedge clk);
    #2;
    reset = 1'b1;
    repeat (50) @(posedge clk);
    #2;
    reset = 1'b0;
    check("reset levels", {timerRun, txEn, irqN, chainGrantOutN}, 7'h03);
    rdchk("timer data kept", 5'h10, r[7:0]);
    rdchk("tx status kept", REG_TX_STATUS, 8'h01);
    rdchk("enable cleared", REG_ENABLE_HI, 8'h00);
    rdchk("vector reset", REG_VECTOR, VECTOR_RESET & 8'hf8);
    finishTest();
  end
endmodule
